// ### hw/nco_pkg.sv
package nco_pkg;

  // datapath widths
  localparam int NCO_ACC_W      = 20;
  localparam int NCO_BYTE_W     = 8;
  localparam int NCO_UPPER_W    = NCO_ACC_W - 16;
  localparam int NCO_CKS_W      = 5;
  localparam int NCO_PWS_W      = 3;
  localparam int NCO_PCNT_W     = 8;

  // register indices; the byte address on the bus is four times the index
  localparam logic [11:0] NCO_IDX_ACCL = 12'h440;
  localparam logic [11:0] NCO_IDX_ACCH = 12'h441;
  localparam logic [11:0] NCO_IDX_ACCU = 12'h442;
  localparam logic [11:0] NCO_IDX_INCL = 12'h443;
  localparam logic [11:0] NCO_IDX_INCH = 12'h444;
  localparam logic [11:0] NCO_IDX_INCU = 12'h445;
  localparam logic [11:0] NCO_IDX_CON  = 12'h446;
  localparam logic [11:0] NCO_IDX_CLK  = 12'h447;
  localparam logic [11:0] NCO_IDX_IRQ  = 12'h448;

  // field positions
  localparam int NCO_CON_EN     = 7;
  localparam int NCO_CON_OUT    = 5;
  localparam int NCO_CON_POL    = 4;
  localparam int NCO_CON_PFM    = 0;
  localparam int NCO_CLK_PWS    = 5;
  localparam int NCO_CLK_CKS    = 0;
  localparam int NCO_IRQ_FLAG   = 0;
  localparam int NCO_IRQ_IE     = 1;

  // values after reset
  localparam logic [NCO_BYTE_W-1:0] NCO_RST_BYTE = 8'h00;
  localparam logic [NCO_ACC_W-1:0]  NCO_RST_WORD = 20'h00000;
  localparam logic [NCO_PCNT_W-1:0] NCO_RST_PCNT = 8'h00;

  // clock source code that means the system clock itself
  localparam logic [NCO_CKS_W-1:0]  NCO_CKS_SYSCLK = 5'h00;
  // clock source code of the high-frequency internal oscillator
  localparam logic [NCO_CKS_W-1:0]  NCO_CKS_HFOSC  = 5'h01;

  // input clock edges from a low increment write to the shadow load
  localparam logic [1:0] NCO_INC_LOAD_TICKS = 2'h2;

  // bus timing and answers
  localparam real NCO_CLK_PERIOD_NS = 4.0;
  localparam logic [1:0] NCO_RESP_OKAY   = 2'h0;
  localparam logic [1:0] NCO_RESP_SLVERR = 2'h2;

  function automatic logic [NCO_PCNT_W-1:0] nco_pulse_ticks(input logic [NCO_PWS_W-1:0] pulse_width_select);
    return 8'h01 << pulse_width_select;
  endfunction

endpackage

// ### hw/nco_if.sv
`timescale 1ns/1ps
interface nco_if;
  import nco_pkg::*;

  logic                   ce;
  logic                   tick;
  logic                   en;
  logic                   pulse_mode_select;
  logic [NCO_PWS_W-1:0]   pulse_width_select;
  logic [NCO_ACC_W-1:0]   inc;
  logic                   inc_wr_low;
  logic                   inc_wr_any;
  logic                   acc_wr;
  logic [1:0]             acc_sel;
  logic [NCO_BYTE_W-1:0]  wdata;
  logic [NCO_ACC_W-1:0]   acc;
  logic                   carry;
  logic                   level;

  modport ctl  (output ce, tick, en, pulse_mode_select, pulse_width_select, inc, inc_wr_low, inc_wr_any,
                output acc_wr, acc_sel, wdata, input acc, carry, level);
  modport core (input ce, tick, en, pulse_mode_select, pulse_width_select, inc, inc_wr_low, inc_wr_any,
                input acc_wr, acc_sel, wdata, output acc, carry, level);
endinterface

// ### hw/nco_core.sv
`timescale 1ns/1ps
module nco_core
  import nco_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control side
  nco_if.core       bus
);

  logic [NCO_ACC_W-1:0]  acc_r;
  logic [NCO_ACC_W-1:0]  shadow_r;
  logic [NCO_ACC_W:0]    sum;
  logic                  ovf;
  logic                  pend_r;
  logic [1:0]            pend_cnt_r;
  logic                  carry_r;
  logic                  level_r;
  logic [NCO_PCNT_W-1:0] pcnt_r;

  assign sum = {1'b0, acc_r} + {1'b0, shadow_r};
  assign ovf = bus.tick & sum[NCO_ACC_W];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      acc_r <= NCO_RST_WORD;
    else if (bus.ce)
    begin
      if (bus.acc_wr)
      begin
        case (bus.acc_sel)
          2'h0:    acc_r[7:0]   <= bus.wdata;
          2'h1:    acc_r[15:8]  <= bus.wdata;
          default: acc_r[19:16] <= bus.wdata[NCO_UPPER_W-1:0];
        endcase
      end
      else if (bus.tick)
        acc_r <= sum[NCO_ACC_W-1:0];
    end
  end

  // shadow is never visible to software, only the byte registers are
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shadow_r   <= NCO_RST_WORD;
      pend_r     <= 1'b0;
      pend_cnt_r <= 2'h0;
    end
    else if (bus.ce)
    begin
      if (!bus.en)
      begin
        pend_r <= 1'b0;
        if (bus.inc_wr_any)
          shadow_r <= bus.inc;
      end
      else if (bus.inc_wr_low)
      begin
        pend_r     <= 1'b1;
        pend_cnt_r <= 2'h0;
      end
      else if (pend_r && bus.tick)
      begin
        if (pend_cnt_r + 2'h1 == NCO_INC_LOAD_TICKS)
        begin
          shadow_r <= bus.inc;
          pend_r   <= 1'b0;
        end
        else
          pend_cnt_r <= pend_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      carry_r <= 1'b0;
    else if (bus.ce)
      carry_r <= ovf;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_r <= 1'b0;
      pcnt_r  <= NCO_RST_PCNT;
    end
    else if (bus.ce && bus.tick)
    begin
      if (ovf)
      begin
        // a new overflow during an active pulse restarts it, so no toggle
        if (bus.pulse_mode_select)
        begin
          level_r <= 1'b1;
          pcnt_r  <= NCO_RST_PCNT;
        end
        else
          level_r <= ~level_r;
      end
      else if (bus.pulse_mode_select && level_r)
      begin
        if (pcnt_r + 8'h01 == nco_pulse_ticks(bus.pulse_width_select))
          level_r <= 1'b0;
        else
          pcnt_r <= pcnt_r + 8'h01;
      end
    end
  end

  assign bus.acc   = acc_r;
  assign bus.carry = carry_r;
  assign bus.level = level_r;

endmodule

// ### hw/nco_top.sv
`timescale 1ns/1ps
// Operation
// - 20-bit accumulator readable/writable as three bytes
// - each input clock edge adds shadow increment
// - carry-out is raw output, rate clk*inc/2^20
// - increment held in low, high, upper bytes
// - enabled: low write loads shadow, second edge
// - disabled: increment write loads shadow immediately
// - shadow increment is not software accessible
// - fixed duty mode toggles output on overflow
// - pulse mode: active after overflow, 1-128 periods
// - pulse longer than overflow interval: no toggle
// - invert bit sets final output polarity
// - polarity change with interrupts and block enabled flags
// - overflow sets the overflow interrupt flag
// - request needs enable, interrupt enable, outer enables
// - flag stays set until software writes zero
// - any reset clears all registers to zero
// - runs independent of system clock, also Sleep; here all logic and edge sampling run on aclk, gated by ce
// - enabled on high-frequency oscillator keeps it running
// - control bit 7 enables the block
// - control bit 5 reads output level
// - input clock picked by clock source select
// - pulse width is 2^field input periods
// - pulse width ignored in fixed duty mode
module nco_top
  import nco_pkg::*;
#(
  parameter int NUM_SRC = 32,
  parameter int ADDR_W  = 16
)
(
  // clock, reset, clock enable
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  // candidate input clocks, index is the clock source code
  input  wire logic [NUM_SRC-1:0] clock_sources,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // axi4-lite read data
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // oscillator outputs to other peripherals
  output logic                    raw_carry_output,
  output logic                    oscillator_output,
  // interrupt side
  output logic                    overflow_interrupt_flag,
  output logic                    irq_request,
  output logic                    high_freq_internal_oscillator_keep
);

  // the upper address check reads bits from 14 up, so a narrower bus cannot be served
  if (NUM_SRC < 2 || NUM_SRC > 32)
  begin : g_bad_num_src
    $error("nco_top: NUM_SRC must lie in 2..32");
  end
  if (ADDR_W < 15 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("nco_top: ADDR_W must lie in 15..32");
  end

  nco_if u_if ();

  nco_core u_core
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (u_if)
  );

  // software-visible state, previous polarity, and write strobes and data for the core
  logic                   en_r;
  logic                   pol_r;
  logic                   pfm_r;
  logic [NCO_PWS_W-1:0]   pws_r;
  logic [NCO_CKS_W-1:0]   cks_r;
  logic [NCO_ACC_W-1:0]   inc_r;
  logic                   ie_r;
  logic                   flag_r;
  logic                   pol_prev_r;
  logic                   inc_wr_low_r;
  logic                   inc_wr_any_r;
  logic                   acc_wr_r;
  logic [1:0]             acc_sel_r;
  logic [NCO_BYTE_W-1:0]  wbyte_r;

  // bus slave state
  logic [ADDR_W-1:0]      aw_addr_r;
  logic                   aw_have_r;
  logic [NCO_BYTE_W-1:0]  w_byte_r;
  logic                   w_lane0_r;
  logic                   w_have_r;
  logic                   do_write;
  logic [11:0]            widx;
  logic                   flag_clr;
  logic                   flag_set;

  // clock source sampling
  logic [NUM_SRC-1:0]     src_s1_r;
  logic [NUM_SRC-1:0]     src_s2_r;
  logic                   sel_prev_r;
  logic                   sel_lvl;
  logic                   tick;

  function automatic logic [11:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[13:2];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    logic [11:0] idx;
    idx = reg_index(addr);
    return (addr[1:0] == 2'h0) && (addr[ADDR_W-1:14] == '0)
           && (idx >= NCO_IDX_ACCL) && (idx <= NCO_IDX_IRQ);
  endfunction

  // pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_s1_r   <= '0;
      src_s2_r   <= '0;
      sel_prev_r <= 1'b0;
    end
    else if (ce)
    begin
      src_s1_r   <= clock_sources;
      src_s2_r   <= src_s1_r;
      sel_prev_r <= sel_lvl;
    end
  end

  // codes beyond the connected sources give no edges
  assign sel_lvl = (32'(cks_r) < NUM_SRC) ? src_s2_r[cks_r] : 1'b0;
  // system clock source adds on every cycle; sleep does not stop aclk here
  assign tick    = ce && en_r && ((cks_r == NCO_CKS_SYSCLK) || (sel_lvl && !sel_prev_r));

  assign u_if.ce         = ce;
  assign u_if.tick       = tick;
  assign u_if.en         = en_r;
  assign u_if.pulse_mode_select        = pfm_r;
  assign u_if.pulse_width_select        = pws_r;
  assign u_if.inc        = inc_r;
  assign u_if.inc_wr_low = inc_wr_low_r;
  assign u_if.inc_wr_any = inc_wr_any_r;
  assign u_if.acc_wr     = acc_wr_r;
  assign u_if.acc_sel    = acc_sel_r;
  assign u_if.wdata      = wbyte_r;

  // write channels are taken independently, response after both
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign widx     = reg_index(aw_addr_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r     <= 1'b0;
      aw_addr_r     <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_r     <= s_axi_awaddr;
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        aw_have_r <= 1'b0;
      else if (!aw_have_r && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_r     <= 1'b0;
      w_byte_r     <= NCO_RST_BYTE;
      w_lane0_r    <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_byte_r     <= s_axi_wdata[7:0];
        w_lane0_r    <= s_axi_wstrb[0];
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        w_have_r <= 1'b0;
      else if (!w_have_r && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= NCO_RESP_OKAY;
    end
    else if (ce)
    begin
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? NCO_RESP_OKAY : NCO_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; lane 0 carries the byte, other lanes are ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_r         <= 1'b0;
      pol_r        <= 1'b0;
      pfm_r        <= 1'b0;
      pws_r        <= '0;
      cks_r        <= '0;
      inc_r        <= NCO_RST_WORD;
      ie_r         <= 1'b0;
      inc_wr_low_r <= 1'b0;
      inc_wr_any_r <= 1'b0;
      acc_wr_r     <= 1'b0;
      acc_sel_r    <= 2'h0;
      wbyte_r      <= NCO_RST_BYTE;
    end
    else if (ce)
    begin
      inc_wr_low_r <= 1'b0;
      inc_wr_any_r <= 1'b0;
      acc_wr_r     <= 1'b0;
      wbyte_r      <= w_byte_r;
      if (do_write && w_lane0_r && mapped(aw_addr_r))
      begin
        case (widx)
          NCO_IDX_ACCL, NCO_IDX_ACCH, NCO_IDX_ACCU:
          begin
            // writes while running take priority over the adder; that cycle's add is lost
            acc_wr_r  <= 1'b1;
            acc_sel_r <= 2'(widx - NCO_IDX_ACCL);
          end
          NCO_IDX_INCL:
          begin
            inc_r[7:0]   <= w_byte_r;
            inc_wr_low_r <= 1'b1;
            inc_wr_any_r <= 1'b1;
          end
          NCO_IDX_INCH:
          begin
            inc_r[15:8]  <= w_byte_r;
            inc_wr_any_r <= 1'b1;
          end
          NCO_IDX_INCU:
          begin
            inc_r[19:16] <= w_byte_r[NCO_UPPER_W-1:0];
            inc_wr_any_r <= 1'b1;
          end
          NCO_IDX_CON:
          begin
            en_r  <= w_byte_r[NCO_CON_EN];
            pol_r <= w_byte_r[NCO_CON_POL];
            pfm_r <= w_byte_r[NCO_CON_PFM];
          end
          NCO_IDX_CLK:
          begin
            pws_r <= w_byte_r[NCO_CLK_PWS +: NCO_PWS_W];
            cks_r <= w_byte_r[NCO_CLK_CKS +: NCO_CKS_W];
          end
          NCO_IDX_IRQ:
            ie_r <= w_byte_r[NCO_IRQ_IE];
          default:
            ie_r <= ie_r;
        endcase
      end
    end
  end

  assign flag_clr = do_write && w_lane0_r && mapped(aw_addr_r) && (widx == NCO_IDX_IRQ)
                    && !w_byte_r[NCO_IRQ_FLAG];
  assign flag_set = u_if.carry || (pol_r != pol_prev_r && ie_r && en_r);

  // a set in the clearing cycle wins so no event is lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_r     <= 1'b0;
      pol_prev_r <= 1'b0;
    end
    else if (ce)
    begin
      flag_r     <= flag_set || (flag_r && !flag_clr);
      pol_prev_r <= pol_r;
    end
  end

  // reads
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= NCO_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= mapped(s_axi_araddr) ? NCO_RESP_OKAY : NCO_RESP_SLVERR;
        s_axi_rdata   <= '0;
        case (reg_index(s_axi_araddr))
          NCO_IDX_ACCL: s_axi_rdata[7:0] <= u_if.acc[7:0];
          NCO_IDX_ACCH: s_axi_rdata[7:0] <= u_if.acc[15:8];
          NCO_IDX_ACCU: s_axi_rdata[NCO_UPPER_W-1:0] <= u_if.acc[19:16];
          NCO_IDX_INCL: s_axi_rdata[7:0] <= inc_r[7:0];
          NCO_IDX_INCH: s_axi_rdata[7:0] <= inc_r[15:8];
          NCO_IDX_INCU: s_axi_rdata[NCO_UPPER_W-1:0] <= inc_r[19:16];
          NCO_IDX_CON:
            s_axi_rdata[7:0] <= {en_r, 1'b0, oscillator_output, pol_r, 3'h0, pfm_r};
          NCO_IDX_CLK:  s_axi_rdata[7:0] <= {pws_r, cks_r};
          NCO_IDX_IRQ:  s_axi_rdata[1:0] <= {ie_r, flag_r};
          default:      s_axi_rdata <= '0;
        endcase
        if (!mapped(s_axi_araddr))
          s_axi_rdata <= '0;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

  // outputs, each from its own flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      raw_carry_output                   <= 1'b0;
      oscillator_output                  <= 1'b0;
      overflow_interrupt_flag            <= 1'b0;
      irq_request                        <= 1'b0;
      high_freq_internal_oscillator_keep <= 1'b0;
    end
    else if (ce)
    begin
      raw_carry_output                   <= u_if.carry;
      oscillator_output                  <= u_if.level ^ pol_r;
      overflow_interrupt_flag            <= flag_r;
      // peripheral and global enables are applied outside the block
      irq_request                        <= flag_r && ie_r && en_r;
      high_freq_internal_oscillator_keep <= en_r && (cks_r == NCO_CKS_HFOSC);
    end
  end

endmodule

// ### tb/nco_monitor.sv
`timescale 1ns/1ps
module nco_monitor
  import nco_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // bus handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  // oscillator side
  input wire logic              raw_carry_output,
  input wire logic              oscillator_output,
  input wire logic              overflow_interrupt_flag,
  input wire logic              irq_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write answer late");
  property p_b_gap;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_gap: assert property (p_b_gap) else $error("write taken while answering");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read answer late");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr > 16'h1120 || s_axi_araddr < 16'h1100)
      |=> s_axi_rresp == NCO_RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_flag;
    $rose(raw_carry_output) |-> ##[0:3] overflow_interrupt_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("carry did not set flag");
  property p_irq;
    irq_request |-> overflow_interrupt_flag;
  endproperty
  a_irq: assert property (p_irq) else $error("request without flag");
  property p_sticky;
    overflow_interrupt_flag && s_axi_awready && s_axi_wready |=> overflow_interrupt_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");
  property p_reset;
    disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !raw_carry_output && !oscillator_output
      && !overflow_interrupt_flag && !irq_request;
  endproperty
  a_reset: assert property (p_reset) else $error("output set after reset");

  c_carry: cover property (raw_carry_output);
  c_irq: cover property (irq_request);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == NCO_RESP_SLVERR);
endmodule

bind nco_top nco_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// ### tb/nco_sink_model.sv
`timescale 1ns/1ps
module nco_sink_model
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // oscillator signals consumed
  input  wire logic carry,
  input  wire logic level,
  // tallies of what arrived
  output int        carries,
  output int        rises,
  output int        last_len
);
  logic level_r;
  int   run_r;

  // only completed high runs reach last_len; rises counts a pulse as soon as it starts
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      carries <= 0;
      rises <= 0;
      last_len <= 0;
      run_r <= 0;
    end
    else
    begin
      if (carry === 1'b1) carries <= carries + 1;
      if (level === 1'b1 && level_r !== 1'b1) rises <= rises + 1;
      if (level === 1'b1) run_r <= run_r + 1;
      else
      begin
        if (run_r > 0) last_len <= run_r;
        run_r <= 0;
      end
    end
    level_r <= level;
  end
endmodule

// ### tb/nco_test.sv
`timescale 1ns/1ps
module nco_test;
  import nco_pkg::*;
  logic        aclk, aresetn, ce;
  logic [31:0] clock_sources, s_axi_wdata, s_axi_rdata;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        raw_carry_output, oscillator_output, overflow_interrupt_flag, irq_request;
  logic        high_freq_internal_oscillator_keep;
  int          mismatches, check_count, carries, rises, last_len, base;

  nco_top dut (.*);
  nco_sink_model sink (.aclk(aclk), .aresetn(aresetn), .carry(raw_carry_output),
    .level(oscillator_output), .carries(carries), .rises(rises), .last_len(last_len));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic results;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [11:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp("rdata", {24'h000000, e}, s_axi_rdata);
    cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  // upper and high bytes go first so the low byte write loads a whole value
  task automatic wr3(input logic [11:0] i, input logic [19:0] v);
    wr(i + 12'h002, {4'h0, v[19:16]});
    wr(i + 12'h001, v[15:8]);
    wr(i, v[7:0]);
  endtask

  task automatic rd3(input logic [11:0] i, input logic [19:0] v);
    rd(i, v[7:0]);
    rd(i + 12'h001, v[15:8]);
    rd(i + 12'h002, {4'h0, v[19:16]});
  endtask

  // one rising edge on source pin 2 is one add
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      clock_sources[2] <= 1'b1;
      repeat (4) @(posedge aclk);
      clock_sources[2] <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    results;
  end

  initial
  begin
    {ce, aresetn, clock_sources, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    ce = 1'b1;
    mismatches = 0;
    check_count = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 9; k++) rd(NCO_IDX_ACCL + 12'(k), 8'h00);
    rd(12'h449, 8'h00, NCO_RESP_SLVERR);
    wr(12'h449, 8'h55, NCO_RESP_SLVERR);
    wr3(NCO_IDX_ACCL, 20'hFFFF0);
    rd3(NCO_IDX_ACCL, 20'hFFFF0);
    wr3(NCO_IDX_INCL, 20'h40000);
    rd3(NCO_IDX_INCL, 20'h40000);
    wr(NCO_IDX_CLK, 8'h02);
    wr(NCO_IDX_IRQ, 8'h02);
    wr(NCO_IDX_CON, 8'h80);
    tick(9);
    cmp("carries", 32'd3, carries);
    cmp("irq_request", 32'd1, {31'h0, irq_request});
    wr(NCO_IDX_CON, 8'h00);
    rd3(NCO_IDX_ACCL, 20'h3FFF0);
    rd(NCO_IDX_CON, 8'h20);
    rd(NCO_IDX_IRQ, 8'h03);
    cmp("overflow_interrupt_flag", 32'd1, {31'h0, overflow_interrupt_flag});
    wr(NCO_IDX_IRQ, 8'h03);
    rd(NCO_IDX_IRQ, 8'h03);
    wr(NCO_IDX_IRQ, 8'h02);
    rd(NCO_IDX_IRQ, 8'h02);
    wr3(NCO_IDX_ACCL, 20'h00000);
    wr3(NCO_IDX_INCL, 20'h00010);
    wr(NCO_IDX_CON, 8'h80);
    wr(NCO_IDX_INCL, 8'h20);
    tick(4);
    wr(NCO_IDX_CON, 8'h00);
    rd3(NCO_IDX_ACCL, 20'h00060);
    wr3(NCO_IDX_INCL, 20'h01000);
    wr(NCO_IDX_CLK, 8'h00);
    wr(NCO_IDX_CON, 8'h81);
    for (int p = 0; p < 8; p++)
    begin
      wr(NCO_IDX_CLK, {3'(p), 5'h00});
      repeat (600) @(posedge aclk);
      cmp("pulse width", 32'd1 << p, last_len);
    end
    wr3(NCO_IDX_INCL, 20'h80000);
    repeat (50) @(posedge aclk);
    base = rises;
    repeat (200) @(posedge aclk);
    cmp("rises", 32'd0, rises - base);
    cmp("oscillator_output", 32'd1, {31'h0, oscillator_output});
    wr(NCO_IDX_CON, 8'h80);
    repeat (50) @(posedge aclk);
    cmp("high run", 32'd2, last_len);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wr(NCO_IDX_IRQ, 8'h02);
    wr(NCO_IDX_CON, 8'h80);
    wr(NCO_IDX_CON, 8'h90);
    repeat (3) @(posedge aclk);
    cmp("oscillator_output", 32'd1, {31'h0, oscillator_output});
    rd(NCO_IDX_IRQ, 8'h03);
    wr(NCO_IDX_CLK, 8'h01);
    repeat (3) @(posedge aclk);
    cmp("keep", 32'd1, {31'h0, high_freq_internal_oscillator_keep});
    wr(NCO_IDX_CLK, 8'h02);
    repeat (3) @(posedge aclk);
    cmp("keep", 32'd0, {31'h0, high_freq_internal_oscillator_keep});
    results;
  end
endmodule
